/* shared/lcd_pkg.sv */
/*
  constants, register map and decode tables for the channel diagnostic path.
  assumes a single channel per instance and an apb register port.
*/
`default_nettype none
package lcd_pkg;
  // apb register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // control bit positions
  localparam int C_TXEN = 0;
  localparam int C_JPATH = 1;
  localparam int C_JCFG0 = 2;
  localparam int C_JCFG1 = 3;
  localparam int C_PRBS = 4;
  localparam int C_INJ = 5;
  localparam int C_RLOOP = 6;
  localparam int C_LLOOP = 7;
  localparam int C_E3 = 8;
  localparam int C_HOST = 9;
  localparam int C_USED = 10;
  // status bit positions
  localparam int S_FLIM = 0;
  localparam int S_PLOSS = 1;
  localparam int S_DFAULT = 2;
  localparam int S_TX_ENABLE_PIN = 3;
  localparam int S_FILL_LO = 8;
  // synchronised input indices
  localparam int I_TXCLK = 0;
  localparam int I_RX_RECOVERED_CLK = 1;
  localparam int I_DJCLK = 2;
  localparam int I_TXP = 3;
  localparam int I_TXN = 4;
  localparam int I_RXP = 5;
  localparam int I_RXN = 6;
  localparam int I_MTIP = 7;
  localparam int I_MRING = 8;
  localparam int I_TXEN = 9;
  localparam int N_IN = 10;
  // loopback and attenuator decode tables
  typedef enum logic [3:0] {
    LP_NONE = 4'b0001, LP_ANALOG = 4'b0010, LP_DIGITAL = 4'b0100, LP_REMOTE = 4'b1000
  } lcd_loop_t;
  localparam logic [1:0] LOOP_CODE_ANALOG = 2'h1;
  localparam logic [1:0] LOOP_CODE_DIGITAL = 2'h3;
  localparam logic [1:0] LOOP_CODE_REMOTE = 2'h2;
  localparam logic [1:0] JA_CODE_16 = 2'h1;
  localparam logic [1:0] JA_CODE_32 = 2'h2;
  localparam logic [5:0] JA_DEPTH_16 = 6'h10;
  localparam logic [5:0] JA_DEPTH_32 = 6'h20;
  localparam logic [5:0] JA_MARGIN = 6'h02;
  // prbs generator and detector
  localparam int PRBS_W = 23;
  localparam logic [22:0] PRBS_SEED = 23'h7f_ffff;
  localparam logic [5:0] PRBS_LOCK = 6'h20;
  localparam logic [2:0] PRBS_LOSS = 3'h4;
endpackage
`default_nettype wire

/* core/lcd_chan_diag.sv */
/*
  channel transmit-path control and diagnostics: drive monitor, transmitter
  on/off, jitter attenuator fifo, prbs generator/detector and loopbacks.
  assumes line and framer clocks far slower than pclk (at least 4x), all
  sampled through two flip-flops; apb master follows the standard protocol.
*/
// Function
// - fault output low while monitor sees transitions
// - fault high after 128 idle clock periods
// - transmitter on needs pin and control bit
// - transmit pins released while transmitter off
// - host mode bit unused: pin and control bit always both needed
// - path select bit places attenuator rx/tx
// - config bits choose depth 16, 32, or off
// - fifo written on data clock, read dejittered
// - limit flag set within two of ends
// - reading limit flag clears fifo and flag
// - prbs enable sends sequence, enables detector
// - violation output low when detector locked
// - out of sync: loss bit and output high
// - inject bit rise inserts one bit error
// - each detected error pulses one rx cycle
// - prbs forces single-rail operation
// - three loopbacks chosen by two bits
// - analog loop: tx output feeds receiver
// - digital loop: tx clock/data to rx outputs
// - remote loop: rx data retransmitted on rx clock
`timescale 1ns/1ps
`default_nettype none
module lcd_chan_diag
  import lcd_pkg::*;
#(
  parameter int DMON_PERIODS = 128,
  parameter int FIFO_MAX = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // framer transmit side
  input wire logic tx_line_clk,
  input wire logic tx_pos_data_in,
  input wire logic tx_neg_data_in,
  input wire logic tx_enable_pin,
  // framer receive side
  output logic rx_recovered_clk,
  output logic rx_pos_data_out,
  output logic rx_neg_data_out,
  output logic rx_neg_violation_out,
  // line receive side, clock from recovery and dejitter clock
  input wire logic line_rx_clk,
  input wire logic line_rx_tip,
  input wire logic line_rx_ring,
  input wire logic dejitter_clk,
  // line transmit side
  output logic line_tx_tip_o,
  output logic line_tx_tip_oe,
  output logic line_tx_ring_o,
  output logic line_tx_ring_oe,
  // drive monitor
  input wire logic monitor_tip_in,
  input wire logic monitor_ring_in,
  output logic drive_fault_out
);

  function automatic lcd_loop_t loop_decode(input logic [1:0] code);
    if (code == LOOP_CODE_ANALOG) return LP_ANALOG;
    if (code == LOOP_CODE_DIGITAL) return LP_DIGITAL;
    if (code == LOOP_CODE_REMOTE) return LP_REMOTE;
    return LP_NONE;
  endfunction

  function automatic logic [5:0] depth_decode(input logic [1:0] code);
    if (code == JA_CODE_16) return JA_DEPTH_16;
    if (code == JA_CODE_32) return JA_DEPTH_32;
    return 6'h00;
  endfunction

  // next prbs bit from history; e3 uses the long sequence
  function automatic logic prbs_fb(input logic [PRBS_W-1:0] s, input logic e3);
    return e3 ? (s[22] ^ s[17]) : (s[14] ^ s[13]);
  endfunction

  // input synchronisers and edge detection
  logic [N_IN-1:0] s1_q, s2_q, s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {tx_enable_pin, monitor_ring_in, monitor_tip_in, line_rx_ring, line_rx_tip,
               tx_neg_data_in, tx_pos_data_in, dejitter_clk, line_rx_clk, tx_line_clk};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  logic tx_e, rxl_e, dj_e;
  assign tx_e = s2_q[I_TXCLK] & ~s3_q[I_TXCLK];
  assign rxl_e = s2_q[I_RX_RECOVERED_CLK] & ~s3_q[I_RX_RECOVERED_CLK];
  assign dj_e = s2_q[I_DJCLK] & ~s3_q[I_DJCLK];

  // control register and decode
  logic [C_USED-1:0] ctrl_q;
  lcd_loop_t lmode;
  logic [5:0] depth;
  logic ja_tx, ja_rx, prbs_on;
  assign lmode = loop_decode({ctrl_q[C_LLOOP], ctrl_q[C_RLOOP]});
  assign depth = depth_decode({ctrl_q[C_JCFG1], ctrl_q[C_JCFG0]});
  assign ja_tx = (depth != 6'h00) & ctrl_q[C_JPATH];
  assign ja_rx = (depth != 6'h00) & ~ctrl_q[C_JPATH];
  assign prbs_on = ctrl_q[C_PRBS];

  // apb slave: zero wait states, error on unmapped offsets
  logic acc, hit, rd_stat;
  logic [31:0] stat_word, rd_mux, prdata_q;
  assign acc = psel & penable;
  assign hit = (paddr == CTRL_OFS) | (paddr == STAT_OFS);
  assign rd_stat = acc & ~pwrite & (paddr == STAT_OFS);
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = prdata_q;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == CTRL_OFS) rd_mux[C_USED-1:0] = ctrl_q;
    if (paddr == STAT_OFS) rd_mux = stat_word;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite) prdata_q <= rd_mux;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= CTRL_RESET[C_USED-1:0];
    else if (acc & pwrite & (paddr == CTRL_OFS)) ctrl_q <= pwdata[C_USED-1:0];
  end

  // transmitter on/off; on needs both the control bit and the pin, the host bit has no effect
  logic tx_on_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_on_q <= 1'b0;
    else tx_on_q <= ctrl_q[C_TXEN] & s2_q[I_TXEN];
  end

  // drive monitor: count transmit clock periods since the last transition
  logic [7:0] dmon_cnt_q;
  logic mon_trans, drive_fault_q;
  assign mon_trans = (s2_q[I_MTIP] ^ s3_q[I_MTIP]) | (s2_q[I_MRING] ^ s3_q[I_MRING]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dmon_cnt_q <= 8'h00;
      drive_fault_q <= 1'b0;
    end else begin
      if (mon_trans) dmon_cnt_q <= 8'h00;
      else if (tx_e && dmon_cnt_q != DMON_PERIODS[7:0]) dmon_cnt_q <= dmon_cnt_q + 8'h01;
      drive_fault_q <= ~mon_trans & (dmon_cnt_q == DMON_PERIODS[7:0]);
    end
  end
  assign drive_fault_out = drive_fault_q;

  // prbs generator with single error injection on a rising control bit
  logic [PRBS_W-1:0] gen_q;
  logic inj_prev_q, inj_pend_q, gen_bit;
  assign gen_bit = prbs_fb(gen_q, ctrl_q[C_E3]) ^ inj_pend_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_q <= PRBS_SEED;
      inj_prev_q <= 1'b0;
      inj_pend_q <= 1'b0;
    end else begin
      inj_prev_q <= ctrl_q[C_INJ];
      if (!prbs_on) inj_pend_q <= 1'b0;
      else if (ctrl_q[C_INJ] & ~inj_prev_q) inj_pend_q <= 1'b1;
      else if (tx_e) inj_pend_q <= 1'b0;
      if (!prbs_on) gen_q <= PRBS_SEED;
      else if (tx_e) gen_q <= {gen_q[PRBS_W-2:0], prbs_fb(gen_q, ctrl_q[C_E3])};
    end
  end

  // data routing through loopbacks and the attenuator
  logic txo_q, tx_p_q, tx_n_q;
  logic [1:0] fifo_rd;
  logic rx_src_e, rx_post_e, tsrc_e, tpost_e, out_e, fw_e;
  logic [1:0] rx_src_d, rx_post_d, tsrc_d, tpost_d, out_d, fw_d;
  always_comb begin
    rx_src_e = (lmode == LP_ANALOG) ? txo_q : rxl_e;
    rx_src_d = (lmode == LP_ANALOG) ? {tx_p_q, tx_n_q} : {s2_q[I_RXP], s2_q[I_RXN]};
    rx_post_e = ja_rx ? dj_e : rx_src_e;
    rx_post_d = ja_rx ? fifo_rd : rx_src_d;
    if (lmode == LP_REMOTE) begin
      tsrc_e = rx_post_e;
      tsrc_d = rx_post_d;
    end else begin
      tsrc_e = tx_e;
      tsrc_d = prbs_on ? {gen_bit, 1'b0} : {s2_q[I_TXP], s2_q[I_TXN]};
    end
    tpost_e = ja_tx ? dj_e : tsrc_e;
    tpost_d = ja_tx ? fifo_rd : tsrc_d;
    fw_e = ja_tx ? tsrc_e : rx_src_e;
    fw_d = ja_tx ? tsrc_d : rx_src_d;
    out_e = (lmode == LP_DIGITAL) ? tx_e : rx_post_e;
    out_d = (lmode == LP_DIGITAL) ? {s2_q[I_TXP], s2_q[I_TXN]} : rx_post_d;
  end

  // jitter attenuator fifo
  logic [1:0] mem [FIFO_MAX];
  logic [4:0] wr_ptr_q, rd_ptr_q;
  logic [5:0] fill_q;
  logic fwr, frd, flim_set, flim_q, ja_chg;
  // a new path or depth would leave stale words and a fill above the depth
  assign ja_chg = acc & pwrite & (paddr == CTRL_OFS) &
                  ({pwdata[C_JPATH], pwdata[C_JCFG1], pwdata[C_JCFG0]} !=
                   {ctrl_q[C_JPATH], ctrl_q[C_JCFG1], ctrl_q[C_JCFG0]});
  assign fwr = fw_e & (ja_tx | ja_rx) & (fill_q < depth);
  assign frd = dj_e & (ja_tx | ja_rx) & (fill_q != 6'h00);
  assign fifo_rd = (fill_q != 6'h00) ? mem[rd_ptr_q] : 2'b00;
  assign flim_set = (ja_tx | ja_rx) & ((fwr & (fill_q >= depth - JA_MARGIN - 6'h01)) |
                    (frd & (fill_q <= JA_MARGIN + 6'h01)));
  always_ff @(posedge pclk) begin
    if (fwr) mem[wr_ptr_q] <= fw_d;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= 5'h00;
      rd_ptr_q <= 5'h00;
      fill_q <= 6'h00;
    end else if (rd_stat || ja_chg || !(ja_tx | ja_rx)) begin
      wr_ptr_q <= 5'h00;
      rd_ptr_q <= 5'h00;
      fill_q <= 6'h00;
    end else begin
      if (fwr) wr_ptr_q <= (wr_ptr_q + 5'h01) & 5'(depth - 6'h01);
      if (frd) rd_ptr_q <= (rd_ptr_q + 5'h01) & 5'(depth - 6'h01);
      if (fwr & ~frd) fill_q <= fill_q + 6'h01;
      else if (frd & ~fwr) fill_q <= fill_q - 6'h01;
    end
  end
  // a new limit event in the read cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flim_q <= 1'b0;
    else flim_q <= flim_set | (flim_q & ~rd_stat);
  end

  // transmit line outputs, released while off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_p_q <= 1'b0;
      tx_n_q <= 1'b0;
      txo_q <= 1'b0;
    end else begin
      txo_q <= tpost_e;
      if (tpost_e) tx_p_q <= tpost_d[1];
      // neg rail drops as soon as prbs starts, not at the next bit
      if (prbs_on) tx_n_q <= 1'b0;
      else if (tpost_e) tx_n_q <= tpost_d[0];
    end
  end
  assign line_tx_tip_o = tx_p_q;
  assign line_tx_ring_o = tx_n_q;
  assign line_tx_tip_oe = tx_on_q;
  assign line_tx_ring_oe = tx_on_q;

  // prbs detector: self-aligning until locked, then free running
  logic [PRBS_W-1:0] det_q;
  logic [5:0] good_q;
  logic [2:0] bad_q;
  logic sync_q, viol_q, exp_bit, mism;
  assign exp_bit = prbs_fb(det_q, ctrl_q[C_E3]);
  assign mism = out_d[1] ^ exp_bit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_q <= '0;
      good_q <= 6'h00;
      bad_q <= 3'h0;
      sync_q <= 1'b0;
      viol_q <= 1'b1;
    end else if (!prbs_on) begin
      good_q <= 6'h00;
      bad_q <= 3'h0;
      sync_q <= 1'b0;
      viol_q <= 1'b1;
    end else if (out_e) begin
      det_q <= {det_q[PRBS_W-2:0], sync_q ? exp_bit : out_d[1]};
      good_q <= mism ? 6'h00 : ((good_q == PRBS_LOCK) ? good_q : good_q + 6'h01);
      viol_q <= ~sync_q | mism;
      if (!sync_q) begin
        if (!mism && good_q == PRBS_LOCK - 6'h01) sync_q <= 1'b1;
        bad_q <= 3'h0;
      end else if (mism) begin
        bad_q <= bad_q + 3'h1;
        if (bad_q == PRBS_LOSS - 3'h1) sync_q <= 1'b0;
      end else if (good_q == PRBS_LOCK) begin
        bad_q <= 3'h0;
      end
    end
  end

  // receive outputs to the framer
  logic rx_p_q, rx_n_q, rx_clk_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_p_q <= 1'b0;
      rx_n_q <= 1'b0;
      rx_clk_q <= 1'b0;
    end else begin
      if (out_e) begin
        rx_p_q <= out_d[1];
        rx_n_q <= out_d[0];
      end
      if (lmode == LP_DIGITAL) rx_clk_q <= s2_q[I_TXCLK];
      else if (ja_rx || (lmode == LP_ANALOG && ja_tx)) rx_clk_q <= s2_q[I_DJCLK];
      else if (lmode == LP_ANALOG) rx_clk_q <= s2_q[I_TXCLK];
      else rx_clk_q <= s2_q[I_RX_RECOVERED_CLK];
    end
  end
  assign rx_recovered_clk = rx_clk_q;
  assign rx_pos_data_out = rx_p_q;
  assign rx_neg_data_out = rx_n_q;
  assign rx_neg_violation_out = prbs_on ? viol_q : rx_n_q;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[S_FLIM] = flim_q;
    stat_word[S_PLOSS] = prbs_on & ~sync_q;
    stat_word[S_DFAULT] = drive_fault_q;
    stat_word[S_TX_ENABLE_PIN] = tx_on_q;
    stat_word[S_FILL_LO +: 6] = fill_q;
  end

  // checks
  property p_fault_clears;
    @(posedge pclk) disable iff (!presetn) mon_trans |=> !drive_fault_out;
  endproperty
  a_fault_clears: assert property (p_fault_clears) else $error("fault stayed high");
  property p_fault_sets;
    @(posedge pclk) disable iff (!presetn)
      (dmon_cnt_q == DMON_PERIODS[7:0] && !mon_trans) |=> drive_fault_out;
  endproperty
  a_fault_sets: assert property (p_fault_sets) else $error("fault not raised");
  property p_tx_on;
    @(posedge pclk) disable iff (!presetn)
      line_tx_tip_oe |-> ($past(ctrl_q[C_TXEN]) && $past(s2_q[I_TXEN]));
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("driver on without enable");
  property p_tx_off;
    @(posedge pclk) disable iff (!presetn) !ctrl_q[C_TXEN] |=> !line_tx_ring_oe;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("driver not released");
  property p_flag_read;
    @(posedge pclk) disable iff (!presetn)
      (rd_stat && !flim_set) |=> (!flim_q && fill_q == 6'h00);
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("read did not clear");
  property p_flag_set;
    @(posedge pclk) disable iff (!presetn) flim_set |=> flim_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("limit flag lost");
  property p_single_rail;
    @(posedge pclk) disable iff (!presetn) (prbs_on && $past(prbs_on)) |-> !line_tx_ring_o;
  endproperty
  a_single_rail: assert property (p_single_rail) else $error("neg rail active in prbs");
  property p_unsync_high;
    @(posedge pclk) disable iff (!presetn)
      (prbs_on && !sync_q) |-> (rx_neg_violation_out && stat_word[S_PLOSS]);
  endproperty
  a_unsync_high: assert property (p_unsync_high) else $error("sync loss not shown");
  property p_inject;
    @(posedge pclk) disable iff (!presetn)
      (prbs_on && ctrl_q[C_INJ] && !inj_prev_q) |=> inj_pend_q;
  endproperty
  a_inject: assert property (p_inject) else $error("injection missed");
  property p_depth;
    @(posedge pclk) disable iff (!presetn) fill_q <= depth;
  endproperty
  a_depth: assert property (p_depth) else $error("fifo over selected depth");
  c_sync: cover property (@(posedge pclk) disable iff (!presetn) prbs_on && sync_q);
  c_fault: cover property (@(posedge pclk) disable iff (!presetn) $rose(drive_fault_out));
  c_limit: cover property (@(posedge pclk) disable iff (!presetn) $rose(flim_q));
  c_err: cover property (@(posedge pclk) disable iff (!presetn) sync_q && out_e && mism);

endmodule
`default_nettype wire

/* bench/lcd_far_end.sv */
/*
  far-end model: framer transmit clock and data, remote line clock and data,
  dejitter clock and the drive monitor taps on the transmit line.
  assumes the bench changes the controls just after pclk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module lcd_far_end (
  // controls from the bench
  input wire logic run_tx,
  input wire logic run_dj,
  input wire logic toggle,
  input wire logic short_mon,
  input wire logic [1:0] tx_val,
  input wire logic [1:0] rx_val,
  // framer and line sources
  output logic tx_line_clk,
  output logic tx_pos_data_in,
  output logic tx_neg_data_in,
  output logic line_rx_clk,
  output logic line_rx_tip,
  output logic line_rx_ring,
  output logic dejitter_clk,
  // transmit line and its taps
  input wire logic line_tx_tip_o,
  input wire logic line_tx_tip_oe,
  input wire logic line_tx_ring_o,
  input wire logic line_tx_ring_oe,
  output logic monitor_tip_in,
  output logic monitor_ring_in
);
  logic ph;
  // clocks rest low while stopped, phases unrelated to pclk
  initial begin
    {tx_line_clk, tx_pos_data_in, tx_neg_data_in, ph} = 4'h0;
    {line_rx_clk, line_rx_tip, line_rx_ring, dejitter_clk} = 4'h0;
    fork
      begin #7; forever #160 tx_line_clk = run_tx & ~tx_line_clk; end
      begin #13; forever #160 line_rx_clk = run_tx & ~line_rx_clk; end
      begin #29; forever #160 dejitter_clk = run_dj & ~dejitter_clk; end
    join
  end
  // framer launches on the falling edge
  always @(negedge tx_line_clk) begin
    ph <= ~ph;
    {tx_pos_data_in, tx_neg_data_in} <= tx_val ^ {2{toggle & ph}};
  end
  always @(negedge line_rx_clk) begin
    {line_rx_tip, line_rx_ring} <= rx_val;
  end
  // released line rests at 0 through its termination; short kills transitions
  assign monitor_tip_in = line_tx_tip_oe & ~short_mon & line_tx_tip_o;
  assign monitor_ring_in = line_tx_ring_oe & ~short_mon & line_tx_ring_o;
endmodule
`default_nettype wire

/* bench/lcd_chan_diag_test.sv */
/*
  self-checking bench: apb register table, then transmitter, loopback,
  prbs, drive monitor and fifo limit cases.
  assumes lcd_far_end supplies the link clocks at 320 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module lcd_chan_diag_test
  import lcd_pkg::*;
;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic err;
  } lcd_row_t;
  typedef struct packed {
    logic [1:0] code;
    logic [1:0] t;
    logic [1:0] r;
    logic [1:0] e;
    logic [1:0] l;
    logic cl;
  } lcd_loop_case_t;
  lcd_row_t rows [5] = '{
    '{CTRL_OFS, 32'h0000_02aa, 32'h0000_02aa, 1'b0},
    '{CTRL_OFS, 32'hffff_ffff, 32'h0000_03ff, 1'b0},
    '{8'h08, 32'h0000_0001, 32'h0000_0000, 1'b1},
    '{8'hfc, 32'h0000_00ff, 32'h0000_0000, 1'b1},
    '{CTRL_OFS, 32'h0000_0000, CTRL_RESET, 1'b0}
  };
  lcd_loop_case_t lc [4] = '{
    '{LOOP_CODE_ANALOG, 2'h2, 2'h1, 2'h2, 2'h2, 1'b1},
    '{LOOP_CODE_DIGITAL, 2'h1, 2'h2, 2'h1, 2'h0, 1'b0},
    '{LOOP_CODE_REMOTE, 2'h2, 2'h1, 2'h1, 2'h1, 1'b1},
    '{2'h0, 2'h2, 2'h1, 2'h1, 2'h2, 1'b1}
  };
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic tx_enable_pin = 1'b0;
  logic run_tx = 1'b0;
  logic run_dj = 1'b0;
  logic toggle = 1'b0;
  logic short_mon = 1'b0;
  logic [1:0] tx_val = 2'h0;
  logic [1:0] rx_val = 2'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, vq, rx_pos, rx_neg, viol, fault, rclk, rc_q;
  logic tip_o, tip_oe, ring_o, ring_oe, monitor_tip_in, monitor_ring_in;
  logic tx_line_clk, tx_pos_data_in, tx_neg_data_in, dejitter_clk;
  logic line_rx_clk, line_rx_tip, line_rx_ring;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_pulse = 0;
  int n_high = 0;
  int n_rclk = 0;

  lcd_chan_diag #(.DMON_PERIODS(8)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_line_clk, .tx_pos_data_in, .tx_neg_data_in, .tx_enable_pin,
    .rx_recovered_clk(rclk), .rx_pos_data_out(rx_pos), .rx_neg_data_out(rx_neg),
    .rx_neg_violation_out(viol), .line_rx_clk, .line_rx_tip, .line_rx_ring,
    .dejitter_clk, .line_tx_tip_o(tip_o), .line_tx_tip_oe(tip_oe),
    .line_tx_ring_o(ring_o), .line_tx_ring_oe(ring_oe), .monitor_tip_in,
    .monitor_ring_in, .drive_fault_out(fault)
  );
  lcd_far_end far (
    .run_tx, .run_dj, .toggle, .short_mon, .tx_val, .rx_val, .tx_line_clk,
    .tx_pos_data_in, .tx_neg_data_in, .line_rx_clk, .line_rx_tip, .line_rx_ring,
    .dejitter_clk, .line_tx_tip_o(tip_o), .line_tx_tip_oe(tip_oe),
    .line_tx_ring_o(ring_o), .line_tx_ring_oe(ring_oe), .monitor_tip_in,
    .monitor_ring_in
  );

  always #20 pclk = ~pclk;
  // monitors sample on the falling edge, clear of launch and counter clears
  always @(negedge pclk) begin
    cyc <= cyc + 1;
    vq <= viol;
    rc_q <= rclk;
    if (viol === 1'b1 && vq === 1'b0) n_pulse++;
    if (viol === 1'b1) n_high++;
    if (rclk === 1'b1 && rc_q === 1'b0) n_rclk++;
    if (cyc == 12000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize;
    $display("mismatches %0d, compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] e);
    cmp_count++;
    if (got !== e) begin
      n_mismatch++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic chk_pin(input logic got, input logic e);
    chk_reg({31'h0, got}, {31'h0, e});
  endtask
  // setup then access, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_stat(input int b, input logic e);
    apb(1'b0, STAT_OFS, 32'h0);
    chk_pin(rdat[b], e);
  endtask
  task automatic bits(input int n);
    repeat (n * 8) @(posedge pclk);
  endtask
  task automatic inj(input logic [31:0] c, input int e);
    n_pulse = 0;
    n_high = 0;
    apb(1'b1, CTRL_OFS, c);
    bits(40);
    chk_reg(n_pulse, e);
    chk_reg(n_high, e * 8);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    chk_pin(tip_oe, 1'b0);
    chk_pin(pready, 1'b1);
    chk_reg(prdata, 32'h0);
    presetn <= 1'b1;
    run_tx <= 1'b1;
    run_dj <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk_pin(rerr, rows[i].err);
      apb(1'b0, rows[i].a, 32'h0);
      chk_reg(rdat, rows[i].q);
      chk_pin(rerr, rows[i].err);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, CTRL_OFS, {22'h0, i[2], 8'h0, i[0]});
      tx_enable_pin <= i[1];
      repeat (8) @(posedge pclk);
      chk_pin(tip_oe, i[1] & i[0]);
      chk_pin(ring_oe, i[1] & i[0]);
      rd_stat(S_TX_ENABLE_PIN, i[1] & i[0]);
    end
    foreach (lc[i]) begin
      apb(1'b1, CTRL_OFS, {24'h0, lc[i].code, 6'h01});
      tx_val <= lc[i].t;
      rx_val <= lc[i].r;
      n_rclk = 0;
      bits(8);
      chk_reg({30'h0, rx_pos, rx_neg}, {30'h0, lc[i].e});
      chk_reg(n_rclk, 32'h8);
      if (lc[i].cl) chk_reg({30'h0, tip_o, ring_o}, {30'h0, lc[i].l});
    end
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, CTRL_OFS, 32'h0000_0041);
      bits(2);
      apb(1'b1, CTRL_OFS, {23'h0, r[0], 8'h51});
      bits(3);
      chk_pin(viol, 1'b1);
      rd_stat(S_PLOSS, 1'b1);
      bits(80);
      chk_pin(viol, 1'b0);
      rd_stat(S_PLOSS, 1'b0);
      chk_pin(ring_o, 1'b0);
      inj({23'h0, r[0], 8'h71}, 1);
      inj({23'h0, r[0], 8'h71}, 0);
      apb(1'b1, CTRL_OFS, {23'h0, r[0], 8'h51});
      inj({23'h0, r[0], 8'h71}, 1);
    end
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    toggle <= 1'b1;
    bits(20);
    chk_pin(fault, 1'b0);
    short_mon <= 1'b1;
    bits(5);
    chk_pin(fault, 1'b0);
    bits(8);
    chk_pin(fault, 1'b1);
    rd_stat(S_DFAULT, 1'b1);
    short_mon <= 1'b0;
    bits(3);
    chk_pin(fault, 1'b0);
    toggle <= 1'b0;
    run_dj <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h0000_000b);
    bits(22);
    rd_stat(S_FLIM, 1'b0);
    bits(36);
    rd_stat(S_FLIM, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    apb(1'b0, STAT_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0000_0007);
    bits(20);
    rd_stat(S_FLIM, 1'b1);
    rd_stat(S_FLIM, 1'b0);
    chk_pin(rdat[13:8] <= 6'h01, 1'b1);
    // receive-path attenuator, read on the running dejitter clock
    rx_val <= 2'h2;
    run_dj <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h0000_0005);
    bits(8);
    n_rclk = 0;
    bits(8);
    chk_reg({30'h0, rx_pos, rx_neg}, 32'h2);
    chk_reg(n_rclk, 32'h8);
    rd_stat(S_FLIM, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
